// *** rtl/mps_defines.vh ***
// What this block does
// - Enable high switches the DC/DC converter on, low switches it off.
// - Core off: pad driver Hi-Z, receiver off, pull off.
// - Enable high, reset low: driver Hi-Z, receiver off, pull on.
// - Out of reset, not configured: driver Hi-Z, receiver on, pull on.
// - Configured: driver and pull per pin, receiver on when driver off.
// - Device reports one of six basic power states, one subsystem active.
`ifndef MPS_DEFINES_VH
`define MPS_DEFINES_VH

// ==========================================
// Sizes
`define MPS_NUM_PADS      8
`define MPS_ADDR_W        8
`define MPS_DATA_W        32

// ==========================================
// Register byte offsets
`define MPS_REG_CTRL      8'h00
`define MPS_REG_STATUS    8'h04
`define MPS_REG_OUT_EN    8'h08
`define MPS_REG_OUT_VAL   8'h0C
`define MPS_REG_PULL_EN   8'h10
`define MPS_REG_PAD_IN    8'h14
`define MPS_REG_SLEEP_CNT 8'h18

// ==========================================
// Control fields and reset values
`define MPS_CTRL_CFG_BIT  0
`define MPS_CTRL_ACT_LSB  1
`define MPS_CTRL_ACT_MSB  3
`define MPS_RST_PADS      8'h00
`define MPS_RST_ACT       3'h0

// ==========================================
// Basic power state codes
`define MPS_PS_IDLE       3'h0
`define MPS_PS_WLAN_TX    3'h1
`define MPS_PS_WLAN_RX    3'h2
`define MPS_PS_SR_TX      3'h3
`define MPS_PS_SR_RX      3'h4
`define MPS_PS_CORE_OFF   3'h5

// ==========================================
// Timing: reset hold the controller must give, for reference
`define MPS_CLK_HZ        10000000
`define MPS_T_RST_MS      5
`define MPS_RST_CYCLES    ((`MPS_CLK_HZ / 1000) * `MPS_T_RST_MS)

`endif

// *** rtl/mps_pad_ctrl.v ***
`timescale 1ns/1ps
`include "mps_defines.vh"
// ==========================================
// Per-pad driver, receiver and pull control
module mps_pad_ctrl (
    // Clock and reset
    input  wire                      clk,
    input  wire                      rst_b,
    input  wire                      ce,
    // Power phase
    input  wire                      coreOff,
    input  wire                      inReset,
    input  wire                      configured,
    // Firmware pad setup
    input  wire [`MPS_NUM_PADS-1:0]  cfgOutEn,
    input  wire [`MPS_NUM_PADS-1:0]  cfgOutVal,
    input  wire [`MPS_NUM_PADS-1:0]  cfgPullEn,
    // Pad controls
    output reg  [`MPS_NUM_PADS-1:0]  padOut,
    output reg  [`MPS_NUM_PADS-1:0]  padOe_b,
    output reg  [`MPS_NUM_PADS-1:0]  padRxEn,
    output reg  [`MPS_NUM_PADS-1:0]  padPullEn
);

    genvar g;
    generate
        for (g = 0; g < `MPS_NUM_PADS; g = g + 1) begin : gPad
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    padOut[g]    <= 1'b0;
                    padOe_b[g]   <= 1'b1;
                    padRxEn[g]   <= 1'b0;
                    padPullEn[g] <= 1'b0;
                end else if (ce) begin
                    if (coreOff) begin
                        padOut[g]    <= 1'b0;
                        padOe_b[g]   <= 1'b1;
                        padRxEn[g]   <= 1'b0;
                        padPullEn[g] <= 1'b0;
                    end else if (inReset) begin
                        padOut[g]    <= 1'b0;
                        padOe_b[g]   <= 1'b1;
                        padRxEn[g]   <= 1'b0;
                        padPullEn[g] <= 1'b1;
                    end else if (!configured) begin
                        padOut[g]    <= 1'b0;
                        padOe_b[g]   <= 1'b1;
                        padRxEn[g]   <= 1'b1;
                        padPullEn[g] <= 1'b1;
                    end else begin
                        padOut[g]    <= cfgOutVal[g];
                        padOe_b[g]   <= ~cfgOutEn[g];
                        padRxEn[g]   <= ~cfgOutEn[g];
                        padPullEn[g] <= cfgPullEn[g];
                    end
                end
            end
        end
    endgenerate

endmodule // mps_pad_ctrl

// *** rtl/mps_power_seq.v ***
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "mps_defines.vh"
// ==========================================
// Power-state sequencer and pad supervisor
module mps_power_seq (
    // Clock and reset
    input  wire                      clk,
    input  wire                      rst_b,
    input  wire                      ce,
    // Power pins from the controller
    input  wire                      moduleEnablePin,
    input  wire                      hardResetPin_b,
    input  wire                      sleepClkPin,
    // Register port
    input  wire [`MPS_ADDR_W-1:0]    regAddr,
    input  wire [`MPS_DATA_W-1:0]    regWrData,
    input  wire                      regWr,
    input  wire                      regRd,
    output reg  [`MPS_DATA_W-1:0]    regRdData,
    // Power outputs
    output reg                       dcdcEnable,
    output reg  [2:0]                powerState,
    // Digital pads
    input  wire [`MPS_NUM_PADS-1:0]  padIn,
    output wire [`MPS_NUM_PADS-1:0]  padOut,
    output wire [`MPS_NUM_PADS-1:0]  padOe_b,
    output wire [`MPS_NUM_PADS-1:0]  padRxEn,
    output wire [`MPS_NUM_PADS-1:0]  padPullEn
);

    // ==========================================
    // Sequencer states
    localparam [3:0] S_OFF  = 4'h1;
    localparam [3:0] S_POR  = 4'h2;
    localparam [3:0] S_DEF  = 4'h4;
    localparam [3:0] S_PROG = 4'h8;

    // ==========================================
    // Address decode, used for every register
    function hit;
        input [`MPS_ADDR_W-1:0] a;
        input [`MPS_ADDR_W-1:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // ==========================================
    // Pin synchronisers
    // Pins come from another board domain, so two stages each, three for the sleep clock
    reg  [1:0]                enSync_q;
    reg  [1:0]                rstSync_q;
    reg  [2:0]                slkSync_q;
    reg  [`MPS_NUM_PADS-1:0]  padMeta_q;
    reg  [`MPS_NUM_PADS-1:0]  padSync_q;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enSync_q  <= 2'h0;
            rstSync_q <= 2'h0;
            slkSync_q <= 3'h0;
            padMeta_q <= `MPS_RST_PADS;
            padSync_q <= `MPS_RST_PADS;
        end else if (ce) begin
            enSync_q  <= {enSync_q[0], moduleEnablePin};
            rstSync_q <= {rstSync_q[0], hardResetPin_b};
            slkSync_q <= {slkSync_q[1:0], sleepClkPin};
            padMeta_q <= padIn;
            padSync_q <= padMeta_q;
        end
    end

    wire enLvl  = enSync_q[1];
    wire rstLvl = rstSync_q[1];
    // Edge detect uses stages two and three, never the first
    wire slkRise = slkSync_q[1] & ~slkSync_q[2];

    // ==========================================
    // Sequencer
    reg  [3:0] state_q;
    reg  [3:0] state_d;
    reg        cfg_q;

    always @* begin
        state_d = state_q;
        case (state_q)
            S_OFF: begin
                if (enLvl) begin
                    state_d = rstLvl ? S_DEF : S_POR;
                end
            end
            S_POR: begin
                if (!enLvl) begin
                    state_d = S_OFF;
                end else if (rstLvl) begin
                    state_d = S_DEF;
                end
            end
            S_DEF: begin
                // Enable low wins: both pins falling together ends in core off
                if (!enLvl) begin
                    state_d = S_OFF;
                end else if (!rstLvl) begin
                    state_d = S_POR;
                end else if (cfg_q) begin
                    state_d = S_PROG;
                end
            end
            S_PROG: begin
                if (!enLvl) begin
                    state_d = S_OFF;
                end else if (!rstLvl) begin
                    state_d = S_POR;
                end else if (!cfg_q) begin
                    state_d = S_DEF;
                end
            end
            default: begin
                state_d = S_OFF;
            end
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= S_OFF;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    wire coreOn  = state_q[2] | state_q[3];
    wire coreOff = state_q[0];
    wire inReset = state_q[1];

    // ==========================================
    // Firmware registers
    // Contents, all but the sleep clock count, are lost whenever the core is off or in reset, as in silicon
    reg  [2:0]                act_q;
    reg  [`MPS_NUM_PADS-1:0]  outEn_q;
    reg  [`MPS_NUM_PADS-1:0]  outVal_q;
    reg  [`MPS_NUM_PADS-1:0]  pullEn_q;
    reg  [15:0]               slkCnt_q;
    wire [2:0]                actWr = regWrData[`MPS_CTRL_ACT_MSB:`MPS_CTRL_ACT_LSB];

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q    <= 1'b0;
            act_q    <= `MPS_RST_ACT;
            outEn_q  <= `MPS_RST_PADS;
            outVal_q <= `MPS_RST_PADS;
            pullEn_q <= `MPS_RST_PADS;
        end else if (ce) begin
            if (!coreOn) begin
                cfg_q    <= 1'b0;
                act_q    <= `MPS_RST_ACT;
                outEn_q  <= `MPS_RST_PADS;
                outVal_q <= `MPS_RST_PADS;
                pullEn_q <= `MPS_RST_PADS;
            end else if (regWr) begin
                if (hit(regAddr, `MPS_REG_CTRL)) begin
                    cfg_q <= regWrData[`MPS_CTRL_CFG_BIT];
                    // Codes above MPS_PS_SR_RX, core off included, are ignored: one subsystem at most
                    if (actWr <= `MPS_PS_SR_RX) begin
                        act_q <= actWr;
                    end
                end
                if (hit(regAddr, `MPS_REG_OUT_EN)) begin
                    outEn_q <= regWrData[`MPS_NUM_PADS-1:0];
                end
                if (hit(regAddr, `MPS_REG_OUT_VAL)) begin
                    outVal_q <= regWrData[`MPS_NUM_PADS-1:0];
                end
                if (hit(regAddr, `MPS_REG_PULL_EN)) begin
                    pullEn_q <= regWrData[`MPS_NUM_PADS-1:0];
                end
            end
        end
    end

    // ==========================================
    // Sleep clock edge counter, shows the low-power clock is alive
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slkCnt_q <= 16'h0000;
        end else if (ce) begin
            if (regWr && hit(regAddr, `MPS_REG_SLEEP_CNT)) begin
                slkCnt_q <= 16'h0000;
            end else if (slkRise) begin
                slkCnt_q <= slkCnt_q + 16'h0001;
            end
        end
    end

    // ==========================================
    // Power outputs
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dcdcEnable <= 1'b0;
            powerState <= `MPS_PS_CORE_OFF;
        end else if (ce) begin
            dcdcEnable <= ~coreOff;
            if (coreOff) begin
                powerState <= `MPS_PS_CORE_OFF;
            end else if (state_q == S_PROG) begin
                powerState <= act_q;
            end else begin
                powerState <= `MPS_PS_IDLE;
            end
        end
    end

    // ==========================================
    // Read port, data stands one cycle after the strobe
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= 32'h0000_0000;
        end else if (ce) begin
            regRdData <= 32'h0000_0000;
            if (regRd) begin
                if (hit(regAddr, `MPS_REG_CTRL)) begin
                    regRdData <= {28'h0, act_q, cfg_q};
                end else if (hit(regAddr, `MPS_REG_STATUS)) begin
                    // Bit 3 is spare so the state code sits on a nibble
                    regRdData <= {21'h0, powerState, state_q, 1'b0, rstLvl, enLvl, dcdcEnable};
                end else if (hit(regAddr, `MPS_REG_OUT_EN)) begin
                    regRdData <= {24'h0, outEn_q};
                end else if (hit(regAddr, `MPS_REG_OUT_VAL)) begin
                    regRdData <= {24'h0, outVal_q};
                end else if (hit(regAddr, `MPS_REG_PULL_EN)) begin
                    regRdData <= {24'h0, pullEn_q};
                end else if (hit(regAddr, `MPS_REG_PAD_IN)) begin
                    // Disabled receivers read as zero
                    regRdData <= {24'h0, padSync_q & padRxEn};
                end else if (hit(regAddr, `MPS_REG_SLEEP_CNT)) begin
                    regRdData <= {16'h0, slkCnt_q};
                end
            end
        end
    end

    // ==========================================
    // Pad control
    mps_pad_ctrl uPads (
        .clk        (clk),
        .rst_b      (rst_b),
        .ce         (ce),
        .coreOff    (coreOff),
        .inReset    (inReset),
        .configured (state_q == S_PROG),
        .cfgOutEn   (outEn_q),
        .cfgOutVal  (outVal_q),
        .cfgPullEn  (pullEn_q),
        .padOut     (padOut),
        .padOe_b    (padOe_b),
        .padRxEn    (padRxEn),
        .padPullEn  (padPullEn)
    );

endmodule // mps_power_seq

// *** dv/mps_power_seq_asserts.sv ***
`timescale 1ns/1ps
`include "mps_defines.vh"
// ==========================================
// Port checker for the power sequencer
module mps_power_seq_asserts (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rst_b,
    input wire logic                     ce,
    // Power pins
    input wire logic                     moduleEnablePin,
    input wire logic                     hardResetPin_b,
    // Power outputs
    input wire logic                     dcdcEnable,
    input wire logic [2:0]               powerState,
    // Pads
    input wire logic [`MPS_NUM_PADS-1:0] padOe_b,
    input wire logic [`MPS_NUM_PADS-1:0] padRxEn,
    input wire logic [`MPS_NUM_PADS-1:0] padPullEn
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Six samples cover the two-stage sync plus state and output registers
    sequence s_offHeld; (ce && !moduleEnablePin) [*6]; endsequence
    sequence s_onHeld; (ce && moduleEnablePin) [*6]; endsequence
    sequence s_porHeld; (ce && moduleEnablePin && !hardResetPin_b) [*6]; endsequence
    property p_offPads; s_offHeld |-> padOe_b == 8'hFF && padRxEn == 8'h00 && padPullEn == 8'h00; endproperty
    property p_offPower; s_offHeld |-> !dcdcEnable && powerState == 3'h5; endproperty
    property p_dcdcOn; s_onHeld |-> dcdcEnable; endproperty
    property p_porPads; s_porHeld |-> padOe_b == 8'hFF && padRxEn == 8'h00 && padPullEn == 8'hFF; endproperty
    property p_rxOff; (padRxEn & ~padOe_b) == 8'h00; endproperty
    property p_drivenPowered; padOe_b != 8'hFF |-> dcdcEnable && powerState != 3'h5; endproperty
    property p_stateRange; powerState <= 3'h5; endproperty
    property p_dcdcMatch; dcdcEnable == (powerState != 3'h5); endproperty
    a_offPads: assert property (p_offPads) else $error("pads active in core off");
    a_offPower: assert property (p_offPower) else $error("converter on with enable low");
    a_dcdcOn: assert property (p_dcdcOn) else $error("converter off with enable high");
    a_porPads: assert property (p_porPads) else $error("pads wrong while held in reset");
    a_rxOff: assert property (p_rxOff) else $error("receiver on at a driven pad");
    a_drivenPowered: assert property (p_drivenPowered) else $error("pad driven without core");
    a_stateRange: assert property (p_stateRange) else $error("power state code out of range");
    a_dcdcMatch: assert property (p_dcdcMatch) else $error("converter and state disagree");
endmodule // mps_power_seq_asserts

bind mps_power_seq mps_power_seq_asserts i_mps_power_seq_asserts (.clk(clk), .rst_b(rst_b), .ce(ce),
    .moduleEnablePin(moduleEnablePin), .hardResetPin_b(hardResetPin_b), .dcdcEnable(dcdcEnable),
    .powerState(powerState), .padOe_b(padOe_b), .padRxEn(padRxEn), .padPullEn(padPullEn));

// *** dv/mps_host_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Board controller driving the power pins
module mps_host_model #(
    parameter int HOLD_CYC = 50000,
    parameter int SLP_HALF = 153
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bench requests
    input wire logic powerReq,
    input wire logic resetReq,
    // Pins to the module, always driven
    output logic     moduleEnablePin,
    output logic     hardResetPin_b,
    output logic     sleepClkPin
);
    logic ioRailUp_q;
    int   holdCnt_q;
    int   slpCnt_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ioRailUp_q      <= 1'b0;
            moduleEnablePin <= 1'b0;
            hardResetPin_b  <= 1'b0;
            holdCnt_q       <= 0;
            slpCnt_q        <= 0;
            sleepClkPin     <= 1'b0;
        end else begin
            // Battery rail is up from the start; I/O rail follows it
            // Both rails stay up for the whole run, so they outlast the pins
            ioRailUp_q <= 1'b1;
            // Free-running sleep clock near 32.768 kHz
            slpCnt_q <= (slpCnt_q == SLP_HALF - 1) ? 0 : slpCnt_q + 1;
            if (slpCnt_q == SLP_HALF - 1) sleepClkPin <= ~sleepClkPin;
            if (!powerReq || !ioRailUp_q) begin
                moduleEnablePin <= 1'b0;
                hardResetPin_b  <= 1'b0;
                holdCnt_q       <= 0;
            end else begin
                moduleEnablePin <= 1'b1;
                if (resetReq) begin
                    hardResetPin_b <= 1'b0;
                    holdCnt_q      <= 0;
                end else if (holdCnt_q >= HOLD_CYC) begin
                    hardResetPin_b <= 1'b1;
                end else begin
                    holdCnt_q <= holdCnt_q + 1;
                end
            end
        end
    end
endmodule // mps_host_model

// *** dv/mps_power_seq_tb_top.sv ***
`timescale 1ns/1ps
`include "mps_defines.vh"
// ==========================================
// Self-checking bench
module mps_power_seq_tb_top;
    logic        clk = 0, rst_b = 0, ce = 1, regWr = 0, regRd = 0, powerReq = 0, resetReq = 0;
    logic [7:0]  regAddr = 8'h00, padIn = 8'hA5;
    logic [31:0] regWrData = 32'h0, d;
    wire         enPin, rstPin_b, slpClk, dcdc;
    wire  [2:0]  ps;
    wire  [31:0] rdData;
    wire  [7:0]  pOut, pOeB, pRx, pPull;
    int          miscompares = 0, n_compared = 0;
    always #50 clk = ~clk;
    // Reset hold shortened from 5 ms so the run stays short
    mps_host_model #(.HOLD_CYC(60), .SLP_HALF(153)) i_mps_host_model (.clk(clk), .rst_b(rst_b),
        .powerReq(powerReq), .resetReq(resetReq), .moduleEnablePin(enPin), .hardResetPin_b(rstPin_b),
        .sleepClkPin(slpClk));
    mps_power_seq i_mps_power_seq (.clk(clk), .rst_b(rst_b), .ce(ce), .moduleEnablePin(enPin),
        .hardResetPin_b(rstPin_b), .sleepClkPin(slpClk), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(rdData), .dcdcEnable(dcdc), .powerState(ps),
        .padIn(padIn), .padOut(pOut), .padOe_b(pOeB), .padRxEn(pRx), .padPullEn(pPull));
    // ==========================================
    // Helpers
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask
    task automatic chkPads(input logic [7:0] oeB, input logic [7:0] rx, input logic [7:0] pull);
        chk("padOe_b", {24'h0, oeB}, {24'h0, pOeB});
        chk("padRxEn", {24'h0, rx}, {24'h0, pRx});
        chk("padPullEn", {24'h0, pull}, {24'h0, pPull});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regWr <= 1'b1; regAddr <= a; regWrData <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        regRd <= 1'b1; regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = rdData;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic waitRelease();
        int i;
        for (i = 0; i < 200 && rstPin_b !== 1'b1; i++) @(posedge clk);
        settle(8);
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_offState();
        chk("dcdc", 32'h0, {31'h0, dcdc});
        chk("powerState", 32'h5, {29'h0, ps});
        chkPads(8'hFF, 8'h00, 8'h00);
        rd(`MPS_REG_STATUS, d); chk("status off", 32'h510, d & 32'h7F1);
        wr(`MPS_REG_OUT_EN, 32'h0F); // Refused while the core is off
    endtask
    task automatic t_powerUp();
        powerReq <= 1'b1; settle(10);
        chk("dcdc", 32'h1, {31'h0, dcdc});
        chk("powerState", 32'h0, {29'h0, ps});
        chkPads(8'hFF, 8'h00, 8'hFF);
        rd(`MPS_REG_STATUS, d); chk("status por", 32'h21, d & 32'h7F1);
        rd(`MPS_REG_OUT_EN, d); chk("outEn kept", 32'h0, d);
        waitRelease();
        chkPads(8'hFF, 8'hFF, 8'hFF);
        rd(`MPS_REG_STATUS, d); chk("status def", 32'h41, d & 32'h7F1);
    endtask
    task automatic t_program();
        int a;
        wr(`MPS_REG_OUT_EN, 32'h0F); wr(`MPS_REG_OUT_VAL, 32'h05); wr(`MPS_REG_PULL_EN, 32'h3C);
        for (a = 0; a < 5; a++) begin
            wr(`MPS_REG_CTRL, (a << 1) | 1); settle(3);
            chk("powerState", a, {29'h0, ps});
        end
        wr(`MPS_REG_CTRL, 32'hB); settle(3);
        chk("bad code", 32'h4, {29'h0, ps});
        // Clock enable low must freeze the activity code
        @(posedge clk);
        ce <= 1'b0;
        wr(`MPS_REG_CTRL, 32'h5);
        settle(3);
        chk("frozen", 32'h4, {29'h0, ps});
        @(posedge clk);
        ce <= 1'b1;
        // Clear just after a sleep clock rise: that rise and two more are counted
        @(posedge slpClk);
        wr(`MPS_REG_SLEEP_CNT, 32'h0);
        settle(700);
        rd(`MPS_REG_SLEEP_CNT, d);
        chk("sleep edges", 32'h3, d);
        chkPads(8'hF0, 8'hF0, 8'h3C);
        chk("padOut", 32'h05, {24'h0, pOut});
        rd(`MPS_REG_PAD_IN, d); chk("padIn", 32'hA0, d);
        rd(8'h1C, d); chk("unmapped", 32'h0, d);
        rd(`MPS_REG_STATUS, d); chk("status prog", 32'h481, d & 32'h7F1);
    endtask
    task automatic t_hardReset();
        resetReq <= 1'b1; settle(10);
        chkPads(8'hFF, 8'h00, 8'hFF);
        chk("dcdc", 32'h1, {31'h0, dcdc});
        resetReq <= 1'b0; waitRelease();
    endtask
    task automatic t_powerDown();
        wr(`MPS_REG_OUT_EN, 32'h0F);
        rd(`MPS_REG_OUT_EN, d);
        chk("outEn set", 32'h0F, d);
        powerReq <= 1'b0; settle(10);
        chk("dcdc", 32'h0, {31'h0, dcdc});
        chk("powerState", 32'h5, {29'h0, ps});
        chkPads(8'hFF, 8'h00, 8'h00);
        powerReq <= 1'b1; waitRelease();
        rd(`MPS_REG_OUT_EN, d); chk("outEn cleared", 32'h0, d);
        powerReq <= 1'b0; settle(10);
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1; settle(2);
        t_offState();
        t_powerUp();
        t_program();
        t_hardReset();
        t_powerDown();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule // mps_power_seq_tb_top
